// ---- hw/pin_override.v ----
// port pin override: picks the compare output or the general port value for the pin
// assumes all inputs come from flip-flops on clk_i; pin outputs are registered
`timescale 1ns/1ns

module pin_override (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [1:0] output_action_select_i,
  input  wire       output_compare_state_i,
  input  wire       port_out_value_i,
  input  wire       output_pin_direction_bit_i,
  output reg        pin_out_o,
  output reg        pin_oe_o
);

  // RULE_06: override on nonzero select
  // RULE_07: mode plays no part here
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o  <= 1'b0;
    end else begin
      pin_out_o <= (output_action_select_i != 2'h0) ? output_compare_state_i : port_out_value_i;
      pin_oe_o  <= output_pin_direction_bit_i; // direction bit alone decides visibility
    end
  end

endmodule

// ---- hw/tick_prescaler.v ----
// timer tick prescaler: one-cycle enable pulses at the selected fraction of clk_i
// assumes clk_i is the only clock; the selection comes from a register on the same clock
`timescale 1ns/1ns
`include "timer8_map.vh"

module tick_prescaler (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] clock_sel_i,
  output reg        timer_tick_o
);

  reg [9:0] div_count;
  reg [9:0] last_value;
  reg       running;

  // terminal count for each selection; unused codes stop the timer
  always @* begin
    last_value = 10'h000;
    running    = 1'b1;
    case (clock_sel_i)
      `CS_DIV1:    last_value = 10'h000;
      `CS_DIV8:    last_value = `DIV8_LAST;
      `CS_DIV64:   last_value = `DIV64_LAST;
      `CS_DIV256:  last_value = `DIV256_LAST;
      `CS_DIV1024: last_value = `DIV1024_LAST;
      default:     running    = 1'b0;
    endcase
  end

  // free divider; restarts when stopped so the first tick after start has a full period
  always @(posedge clk_i) begin
    if (rst_i || !running) begin
      div_count    <= 10'h000;
      timer_tick_o <= 1'b0;
    end else if (div_count >= last_value) begin
      div_count    <= 10'h000;
      timer_tick_o <= 1'b1;
    end else begin
      div_count    <= div_count + 10'h001;
      timer_tick_o <= 1'b0;
    end
  end

endmodule

// ---- hw/timer8_compare_waveform_unit.v ----
// 8-bit timer with compare output and waveform generation behind a classic wishbone slave
// Overview of operation
// RULE_01: a counter write blocks every compare match during the following timer tick
// RULE_02: software sets up the compare output before turning the pin to output
// RULE_03: changing waveform mode never alters the output compare state
// RULE_04: a new action selection governs the very next compare match
// RULE_05: reset clears the output compare state to zero
// RULE_06: nonzero action selection puts compare state on pin; direction bit still rules
// RULE_07: the pin override depends only on the action selection, not the mode
// RULE_08: action selection zero leaves the compare state unchanged at a match
// RULE_09: in non-PWM modes a force strobe applies the selected action at once
// RULE_10: mode bits choose counting; action bits choose only output behaviour
// RULE_11: normal mode always increments, never clears on match, wraps 0xFF to 0x00
// RULE_12: normal mode sets the overflow flag in the tick the counter becomes zero
// RULE_13: clear-on-match mode resets the counter to zero on a compare match
// RULE_14: clear-on-match compare writes act directly; a low value waits for wrap
// RULE_15: clear-on-match with action one toggles the compare state every match
// RULE_16: clear-on-match sets overflow in the tick passing from maximum to 0x00
// RULE_17: fast PWM counts from zero to maximum, then clears on the next tick
// RULE_18: fast PWM action two clears on match, sets at bottom; three reverses
// RULE_19: fast PWM sets the overflow flag each time the counter reaches maximum
// RULE_20: fast PWM compare at maximum gives constant level; zero gives one-tick spike
// RULE_21: fast PWM with action one toggles on each match for a square wave
// RULE_22: fast PWM double buffers the compare value written by the CPU
// RULE_23: maximum is 0xFF and bottom is 0x00 for all mode and flag logic
// RULE_24: the buffered compare value loads only at top or bottom of the count
// RULE_25: a match sets the compare flag at the next tick; writing one clears it
// RULE_26: all updates happen on clk_i qualified by the one-cycle timer tick; CPU writes, flag clears and force strobes act without the tick
// RULE_27: a CPU counter write overrides any clear or count in the same cycle
// assumes a classic wishbone master on clk_i and a port pin pad driven by pin_out_o/pin_oe_o
`timescale 1ns/1ns
`include "timer8_map.vh"

module timer8_compare_waveform_unit (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        pin_out_o,
  output wire        pin_oe_o,
  output reg         overflow_flag_o,
  output reg         compare_flag_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // functions

  // compare match action, also used by the force strobe and fast PWM matches
  function apply_match;
    input [1:0] sel;
    input       cur;
    begin
      case (sel)
        `ACT_TOGGLE: apply_match = ~cur;
        `ACT_CLEAR:  apply_match = 1'b0;
        `ACT_SET:    apply_match = 1'b1;
        default:     apply_match = cur;
      endcase
    end
  endfunction

  // fast PWM bottom action: opposite of the match action, toggle mode leaves it alone
  function apply_bottom;
    input [1:0] sel;
    input       cur;
    begin
      case (sel)
        `ACT_CLEAR: apply_bottom = 1'b1;
        `ACT_SET:   apply_bottom = 1'b0;
        default:    apply_bottom = cur;
      endcase
    end
  endfunction

  // only fast PWM is treated as a buffered PWM mode in this block
  function is_pwm;
    input [1:0] mode;
    begin
      is_pwm = (mode == `MODE_FAST_PWM);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // state

  reg [1:0] waveform_mode_select;
  reg [1:0] output_action_select;
  reg [2:0] clock_sel;
  reg [7:0] counter_value;
  reg [7:0] compare_value;
  reg [7:0] compare_buffer;
  reg       output_compare_state;
  reg       port_out_value;
  reg       output_pin_direction_bit;
  reg       block_match;

  reg [7:0] next_counter;
  reg       next_state;
  reg [7:0] next_compare;

  wire       timer_tick;
  wire       bus_req;
  wire       bus_wr;
  wire       lane0;
  wire       wr_control;
  wire       wr_counter;
  wire       wr_compare;
  wire       wr_flags;
  wire       wr_port;
  wire       force_compare_strobe;
  wire [1:0] new_mode;
  wire [1:0] new_action;
  wire       at_max;
  wire       match_now;
  wire       tick_match;
  wire       tick_max;
  wire       clr_overflow;
  wire       clr_compare;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // bus decode

  // the access takes effect at the edge where the master sees ack high
  assign bus_req    = wb_cyc_i & wb_stb_i;
  assign bus_wr     = bus_req & wb_we_i & wb_ack_o;
  assign lane0      = wb_sel_i[0]; // every register lives in the low byte
  assign wr_control = bus_wr & lane0 & (wb_adr_i == `ADR_CONTROL);
  assign wr_counter = bus_wr & lane0 & (wb_adr_i == `ADR_COUNTER);
  assign wr_compare = bus_wr & lane0 & (wb_adr_i == `ADR_COMPARE);
  assign wr_flags   = bus_wr & lane0 & (wb_adr_i == `ADR_FLAGS);
  assign wr_port    = bus_wr & lane0 & (wb_adr_i == `ADR_PORT);

  assign new_mode   = wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign new_action = wb_dat_i[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB];

  // strobe acts with the mode and action written alongside it; ignored in PWM
  assign force_compare_strobe = wr_control & wb_dat_i[`CTRL_FORCE_BIT] & ~is_pwm(new_mode);

  // write-one-to-clear flag bits
  assign clr_overflow = wr_flags & wb_dat_i[`FLAG_OVERFLOW_BIT];
  assign clr_compare  = wr_flags & wb_dat_i[`FLAG_COMPARE_BIT];

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read data captured as ack rises; unmapped addresses read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        `ADR_CONTROL: begin
          wb_dat_o[`CTRL_MODE_MSB:`CTRL_MODE_LSB]     <= waveform_mode_select;
          wb_dat_o[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB] <= output_action_select;
          wb_dat_o[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB] <= clock_sel;
        end
        `ADR_COUNTER: begin
          wb_dat_o[7:0] <= counter_value;
        end
        `ADR_COMPARE: begin
          // the CPU sees the buffer in PWM and the active value otherwise
          wb_dat_o[7:0] <= is_pwm(waveform_mode_select) ? compare_buffer : compare_value;
        end
        `ADR_FLAGS: begin
          wb_dat_o[`FLAG_OVERFLOW_BIT] <= overflow_flag_o;
          wb_dat_o[`FLAG_COMPARE_BIT]  <= compare_flag_o;
          wb_dat_o[`FLAG_OCSTATE_BIT]  <= output_compare_state;
        end
        `ADR_PORT: begin
          wb_dat_o[`PORT_VALUE_BIT] <= port_out_value;
          wb_dat_o[`PORT_DIR_BIT]   <= output_pin_direction_bit;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // control registers

  // RULE_04: action bits unbuffered
  // RULE_03: mode write keeps compare state
  always @(posedge clk_i) begin
    if (rst_i) begin
      waveform_mode_select     <= `RST_MODE;
      output_action_select     <= `RST_ACTION;
      clock_sel                <= `RST_CLKSEL;
      port_out_value           <= 1'b0;
      output_pin_direction_bit <= 1'b0;
    end else begin
      if (wr_control) begin
        waveform_mode_select <= new_mode;
        output_action_select <= new_action;
        clock_sel            <= wb_dat_i[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB];
      end
      // RULE_02: software initialises state first
      if (wr_port) begin
        port_out_value           <= wb_dat_i[`PORT_VALUE_BIT];
        output_pin_direction_bit <= wb_dat_i[`PORT_DIR_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // timer tick

  tick_prescaler u_prescaler (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .clock_sel_i  (clock_sel),
    .timer_tick_o (timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // comparator

  // RULE_23: fixed maximum and bottom
  assign at_max = (counter_value == `COUNT_MAX);

  // RULE_01: blocked for one tick
  assign match_now  = (counter_value == compare_value) & ~block_match;
  // RULE_26: everything qualified by tick
  assign tick_match = timer_tick & match_now;
  assign tick_max   = timer_tick & at_max;

  // RULE_01: block set by counter write
  // the block stays armed while the timer is stopped, ending only at the next tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      block_match <= 1'b0;
    end else if (wr_counter) begin
      block_match <= 1'b1;
    end else if (timer_tick) begin
      block_match <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // counter

  // RULE_10: only mode steers counting
  always @* begin
    next_counter = counter_value;
    if (timer_tick) begin
      case (waveform_mode_select)
        // RULE_13: clear on match
        // RULE_14: missed match waits for wrap
        `MODE_CLEAR_MATCH: begin
          if (match_now) begin
            next_counter = `COUNT_BOTTOM;
          end else begin
            next_counter = counter_value + 8'h01;
          end
        end
        // RULE_17: single slope to maximum
        `MODE_FAST_PWM: begin
          if (at_max) begin
            next_counter = `COUNT_BOTTOM;
          end else begin
            next_counter = counter_value + 8'h01;
          end
        end
        // RULE_11: plain increment and wrap
        default: begin
          next_counter = counter_value + 8'h01;
        end
      endcase
    end
    // RULE_27: cpu write wins
    if (wr_counter) begin
      next_counter = wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      counter_value <= `RST_BYTE;
    end else begin
      counter_value <= next_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // compare value and buffer

  // RULE_22: pwm writes go to buffer
  // RULE_24: load at top only
  // RULE_14: direct write outside pwm
  always @* begin
    next_compare = compare_value;
    if (is_pwm(waveform_mode_select) && tick_max) begin
      next_compare = compare_buffer;
    end
    if (wr_compare && !is_pwm(waveform_mode_select)) begin
      next_compare = wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_value  <= `RST_BYTE;
      compare_buffer <= `RST_BYTE;
    end else begin
      compare_value <= next_compare;
      if (wr_compare) begin
        compare_buffer <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // waveform generator

  // the bottom action is applied after the match action, so bottom wins at a shared tick;
  // that gives the constant level with compare at maximum and the spike with compare at zero
  always @* begin
    next_state = output_compare_state;
    if (timer_tick) begin
      case (waveform_mode_select)
        `MODE_FAST_PWM: begin
          // RULE_21: toggle on every match
          // RULE_18: clear or set pairs
          if (match_now) begin
            next_state = apply_match(output_action_select, next_state);
          end
          // RULE_20: bottom wins at maximum
          if (at_max) begin
            next_state = apply_bottom(output_action_select, next_state);
          end
        end
        // RULE_15: toggle in clear-on-match
        // RULE_08: zero select keeps state
        `MODE_NORMAL, `MODE_CLEAR_MATCH: begin
          if (match_now) begin
            next_state = apply_match(output_action_select, next_state);
          end
        end
        default: begin
          next_state = output_compare_state; // phase correct output not built
        end
      endcase
    end
    // RULE_09: force acts immediately
    if (force_compare_strobe) begin
      next_state = apply_match(new_action, output_compare_state);
    end
  end

  // RULE_05: reset clears state
  always @(posedge clk_i) begin
    if (rst_i) begin
      output_compare_state <= 1'b0;
    end else begin
      output_compare_state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // flags

  // RULE_12: overflow as counter hits zero
  // RULE_16: overflow leaving maximum
  // RULE_19: overflow at maximum
  // a fresh set beats a simultaneous clear so no event is lost
  always @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_o <= 1'b0;
    end else begin
      overflow_flag_o <= tick_max | (overflow_flag_o & ~clr_overflow);
    end
  end

  // RULE_25: match flags at tick
  // force strobes never set this flag, only true matches do
  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_flag_o <= 1'b0;
    end else begin
      compare_flag_o <= tick_match | (compare_flag_o & ~clr_compare);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // pin

  // RULE_06: pin override
  pin_override u_pin (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .output_action_select_i     (output_action_select),
    .output_compare_state_i     (output_compare_state),
    .port_out_value_i           (port_out_value),
    .output_pin_direction_bit_i (output_pin_direction_bit),
    .pin_out_o                  (pin_out_o),
    .pin_oe_o                   (pin_oe_o)
  );

endmodule

// ---- hw/timer8_map.vh ----
// offsets, fields, resets and prescale counts of the timer
// assumes inclusion by bare name
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// register byte addresses
`define ADR_CONTROL        8'h00
`define ADR_COUNTER        8'h04
`define ADR_COMPARE        8'h08
`define ADR_FLAGS          8'h0C
`define ADR_PORT           8'h10

// control register fields
`define CTRL_MODE_LSB      0
`define CTRL_MODE_MSB      1
`define CTRL_ACTION_LSB    2
`define CTRL_ACTION_MSB    3
`define CTRL_CLKSEL_LSB    4
`define CTRL_CLKSEL_MSB    6
`define CTRL_FORCE_BIT     7

// flag register fields
`define FLAG_OVERFLOW_BIT  0
`define FLAG_COMPARE_BIT   1
`define FLAG_OCSTATE_BIT   2

// port register fields
`define PORT_VALUE_BIT     0
`define PORT_DIR_BIT       1

// waveform modes
`define MODE_NORMAL        2'h0
`define MODE_PHASE         2'h1
`define MODE_CLEAR_MATCH   2'h2
`define MODE_FAST_PWM      2'h3

// output actions
`define ACT_NONE           2'h0
`define ACT_TOGGLE         2'h1
`define ACT_CLEAR          2'h2
`define ACT_SET            2'h3

// counter extremes
`define COUNT_MAX          8'hFF
`define COUNT_BOTTOM       8'h00

// reset values
`define RST_BYTE           8'h00
`define RST_MODE           2'h0
`define RST_ACTION         2'h0
`define RST_CLKSEL         3'h0

// clock select codes and prescale terminal counts (divisor minus one)
`define CS_STOP            3'h0
`define CS_DIV1            3'h1
`define CS_DIV8            3'h2
`define CS_DIV64           3'h3
`define CS_DIV256          3'h4
`define CS_DIV1024         3'h5
`define DIV8_LAST          10'h007
`define DIV64_LAST         10'h03F
`define DIV256_LAST        10'h0FF
`define DIV1024_LAST       10'h3FF

`endif

// ---- testbench/pin_load_model.sv ----
// external load on the timer output pin
// assumes the pad has a weak pull-down and nothing else drives it
`timescale 1ns/1ns

module pin_load_model (
  input  wire pin_out_i,
  input  wire pin_oe_i,
  output wire pad_o
);
  // direction gates visibility
  // released pad falls to the pull-down
  assign pad_o = pin_oe_i ? pin_out_i : 1'b0;
endmodule

// ---- testbench/timer8_compare_waveform_unit_tb_top.sv ----
// self-checking bench for the timer compare and waveform unit
// assumes the map header on the include path and a 100 ns clock
`timescale 1ns/1ns
`include "timer8_map.vh"

module timer8_compare_waveform_unit_tb_top;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire        ack;
  wire        pin_out;
  wire        pin_oe;
  wire        ovf;
  wire        cmpf;
  wire        pad;
  reg  [31:0] seed = 32'h0000_6CD5;
  reg  [19:0] row;
  reg  [7:0]  q;
  reg         st;
  integer     failures = 0;
  integer     tests_run = 0;
  integer     i, hi, tg;

  timer8_compare_waveform_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .overflow_flag_o(ovf), .compare_flag_o(cmpf));
  pin_load_model i_load (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pad_o(pad));

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////
  // expectation helpers
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [7:0] ctl(input [1:0] m, input [1:0] a, input [2:0] cs, input f);
    ctl = {f, cs, a, m};
  endfunction
  function nxt(input s, input [1:0] a);
    nxt = (a == `ACT_TOGGLE) ? ~s : (a == `ACT_NONE) ? s : (a == `ACT_SET);
  endfunction
  function near(input integer a, input integer b, input integer t);
    near = (a >= b - t) && (a <= b + t);
  endfunction

  task end_sim;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // hold until ack is sampled, then idle
  task bus(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      check(n < 20, 1'b1, "bus answer");
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rd_chk(input [7:0] a, input [7:0] e, input string what);
    begin
      bus(1'b0, a, 8'h00);
      check(q, e, what);
    end
  endtask
  task run(input [1:0] m, input [1:0] a, input integer n);
    begin
      wr(`ADR_CONTROL, ctl(m, a, `CS_DIV1, 1'b0));
      repeat (n) @(posedge clk_i);
      wr(`ADR_CONTROL, ctl(m, a, `CS_STOP, 1'b0));
      bus(1'b0, `ADR_COUNTER, 8'h00);
    end
  endtask
  // high cycles and edges on the pad
  task sample(input integer n);
    reg last;
    begin
      hi = 0;
      tg = 0;
      last = pad;
      repeat (n) begin
        @(posedge clk_i);
        hi = hi + pad;
        tg = tg + (pad != last);
        last = pad;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // random forces, hand-picked corners
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(`ADR_FLAGS, 8'h00, "reset flags");
    rd_chk(8'h20, 8'h00, "unmapped");
    // state set up while the pin is an input
    st = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      wr(`ADR_CONTROL, ctl(`MODE_NORMAL, seed[1:0], `CS_STOP, 1'b1));
      st = nxt(st, seed[1:0]);
      rd_chk(`ADR_FLAGS, {5'h00, st, 2'h0}, "forced state");
    end
    wr(`ADR_CONTROL, ctl(`MODE_NORMAL, `ACT_SET, `CS_STOP, 1'b1));
    wr(`ADR_CONTROL, ctl(`MODE_CLEAR_MATCH, `ACT_NONE, `CS_STOP, 1'b0));
    rd_chk(`ADR_FLAGS, 8'h04, "mode change");
    wr(`ADR_PORT, 8'h02);
    check(pad, 1'b0, "port value");
    wr(`ADR_CONTROL, ctl(`MODE_FAST_PWM, `ACT_SET, `CS_STOP, 1'b0));
    repeat (2) @(posedge clk_i);
    check(pad, 1'b1, "override");
    wr(`ADR_PORT, 8'h01);
    repeat (2) @(posedge clk_i);
    check(pad, 1'b0, "released pin");
    wr(`ADR_PORT, 8'h02);
    // counter written equal to compare, then started
    wr(`ADR_CONTROL, ctl(`MODE_NORMAL, `ACT_NONE, `CS_STOP, 1'b0));
    wr(`ADR_COMPARE, 8'h40);
    wr(`ADR_COUNTER, 8'h40);
    run(`MODE_NORMAL, `ACT_NONE, 30);
    check(cmpf, 1'b0, "blocked match");
    run(`MODE_NORMAL, `ACT_NONE, 260);
    check(ovf, 1'b1, "overflow");
    check(cmpf, 1'b1, "match flag");
    check(q > 8'h40, 1'b1, "no clear on match");
    wr(`ADR_FLAGS, 8'h02);
    check({ovf, cmpf}, 2'h2, "flag clear");
    wr(`ADR_COMPARE, 8'h05);
    wr(`ADR_COUNTER, 8'h00);
    run(`MODE_CLEAR_MATCH, `ACT_NONE, 20);
    check(q <= 8'h05, 1'b1, "clear on match");
    wr(`ADR_COUNTER, 8'h20);
    run(`MODE_CLEAR_MATCH, `ACT_NONE, 40);
    check(q > 8'h20, 1'b1, "late compare");
    // random toggle periods in clear-on-match mode
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      wr(`ADR_COMPARE, {5'h00, seed[2:0]} | 8'h01);
      wr(`ADR_COUNTER, 8'h00);
      wr(`ADR_CONTROL, ctl(`MODE_CLEAR_MATCH, `ACT_TOGGLE, `CS_DIV1, 1'b0));
      sample(96);
      check(near(tg, 96 / ((seed[2:0] | 3'h1) + 1), 1), 1'b1, "toggle rate");
      wr(`ADR_CONTROL, ctl(`MODE_CLEAR_MATCH, `ACT_TOGGLE, `CS_STOP, 1'b0));
    end
    // fast pwm: action, compare, high cycles in two periods
    for (i = 0; i < 6; i = i + 1) begin
      case (i)
        0: row = {2'h2, 8'h40, 10'h082};
        1: row = {2'h3, 8'h40, 10'h17E};
        2: row = {2'h2, 8'hFF, 10'h200};
        3: row = {2'h3, 8'hFF, 10'h000};
        4: row = {2'h2, 8'h00, 10'h002};
        default: row = {2'h1, 8'h40, 10'h100};
      endcase
      wr(`ADR_CONTROL, ctl(`MODE_FAST_PWM, row[19:18], `CS_STOP, 1'b0));
      wr(`ADR_COMPARE, row[17:10]);
      wr(`ADR_CONTROL, ctl(`MODE_FAST_PWM, row[19:18], `CS_DIV1, 1'b0));
      repeat (300) @(posedge clk_i);
      sample(512);
      check(near(hi, row[9:0], 1), 1'b1, "pwm duty");
    end
    end_sim;
  end

  // watchdog, run needs ~5700 cycles
  initial begin
    #(100 * 30000);
    failures = failures + 1;
    end_sim;
  end
endmodule

bind timer8_compare_waveform_unit timer8_cwu_properties i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .overflow_flag_o(overflow_flag_o), .compare_flag_o(compare_flag_o));

// ---- testbench/timer8_cwu_properties.sv ----
// port checker for the timer compare unit
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`include "timer8_map.vh"

module timer8_cwu_properties (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        pin_out_o,
  input wire        pin_oe_o,
  input wire        overflow_flag_o,
  input wire        compare_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////
  // bus events at the ack edge
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire ctl_wr = wr & (wb_adr_i == `ADR_CONTROL);
  wire fl_wr = wr & (wb_adr_i == `ADR_FLAGS);
  wire frc = ctl_wr & wb_dat_i[`CTRL_FORCE_BIT] & (wb_dat_i[1:0] != `MODE_FAST_PWM);
  wire [1:0] act = wb_dat_i[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB];
  wire known = (wb_adr_i == `ADR_CONTROL) | (wb_adr_i == `ADR_COUNTER) | (wb_adr_i == `ADR_COMPARE)
             | (wb_adr_i == `ADR_FLAGS) | (wb_adr_i == `ADR_PORT);

  // force writes reach the pin two edges later
  sequence force_set_s;
    frc && act == `ACT_SET;
  endsequence
  sequence force_clr_s;
    frc && act == `ACT_CLEAR;
  endsequence

  ////////////////////////////////////////////////////////////////
  // reset wins, so no disable
  reset_clears_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !pin_oe_o && !pin_out_o
    && !overflow_flag_o && !compare_flag_o) else $error("reset missed");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits set");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !known |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read");
  dir_follow_a: assert property (wr && wb_adr_i == `ADR_PORT |-> ##2
    pin_oe_o == $past(wb_dat_i[`PORT_DIR_BIT], 2)) else $error("pin enable wrong");
  force_set_a: assert property (force_set_s |-> ##2 pin_out_o) else $error("force set lost");
  force_clr_a: assert property (force_clr_s |-> ##2 !pin_out_o) else $error("force clear lost");
  // flags fall only after a flag write
  cmp_sticky_a: assert property ($fell(compare_flag_o) |-> $past(fl_wr) || $past(fl_wr, 2))
    else $error("compare flag lost");
  ovf_sticky_a: assert property ($fell(overflow_flag_o) |-> $past(fl_wr) || $past(fl_wr, 2))
    else $error("overflow flag lost");
endmodule
